// >>> shared/usart_status_pkg.sv
package usart_status_pkg;

  // ***********************************************
  // Widths and buffer size
  // ***********************************************
  localparam int DATA_W     = 8;
  localparam int FIFO_DEPTH = 8;
  localparam int PIN_W      = 14;

  // ***********************************************
  // Status byte bit positions
  // ***********************************************
  localparam int ST_TX_FREE  = 0;
  localparam int ST_RX_READY = 1;
  localparam int ST_TX_IDLE  = 2;
  localparam int ST_PARITY   = 3;
  localparam int ST_OVERRUN  = 4;
  localparam int ST_FRAMING  = 5;
  localparam int ST_SYNC     = 6;
  localparam int ST_MODEM    = 7;

  // ***********************************************
  // Command byte bit positions
  // ***********************************************
  localparam int CMD_TX_EN   = 0;
  localparam int CMD_DTR     = 1;
  localparam int CMD_RX_EN   = 2;
  localparam int CMD_BREAK   = 3;
  localparam int CMD_ERR_CLR = 4;
  localparam int CMD_RTS     = 5;
  localparam int CMD_INT_RST = 6;
  localparam int CMD_HUNT    = 7;
  // Bits kept after a command write; the rest act once
  localparam logic [7:0] CMD_KEEP_MASK = 8'h2f;

  // ***********************************************
  // Mode byte field positions
  // ***********************************************
  localparam int MODE_BAUD_LSB = 0;
  localparam int MODE_LEN_LSB  = 2;
  localparam int MODE_PAR_EN   = 4;
  localparam int MODE_PAR_EVEN = 5;
  localparam int MODE_STOP_LSB = 6;

  // ***********************************************
  // Values after reset
  // ***********************************************
  localparam logic [7:0]        MODE_RST = 8'h00;
  localparam logic [7:0]        CMD_RST  = 8'h00;
  localparam logic [PIN_W-1:0]  PIN_RST  = 14'h3fff;

  // Control port write sequence
  typedef enum logic [0:0] {EXPECT_MODE, EXPECT_CMD} phase_type;

endpackage : usart_status_pkg

// >>> rtl/tx_hold_fifo.sv
`timescale 1ns/1ns
module tx_hold_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input  wire logic             core_clk,
  input  wire logic             rst,
  // Fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr_r;
  logic [AW-1:0]    wr_ptr_nxt;
  logic [AW-1:0]    rd_ptr_r;
  logic [AW-1:0]    rd_ptr_nxt;
  logic [AW:0]      count_r;
  logic [AW:0]      count_nxt;
  logic             push;
  logic             pop;

  // Honest full and empty from the fill count
  assign in_ready  = (count_r != (AW+1)'(DEPTH));
  assign out_valid = (count_r != '0);
  assign out_data  = mem[rd_ptr_r];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  // Pointer and count next values
  always_comb begin
    wr_ptr_nxt = wr_ptr_r;
    rd_ptr_nxt = rd_ptr_r;
    count_nxt  = count_r;
    if (push) begin
      wr_ptr_nxt = (wr_ptr_r == AW'(DEPTH-1)) ? '0 : wr_ptr_r + 1'b1;
    end
    if (pop) begin
      rd_ptr_nxt = (rd_ptr_r == AW'(DEPTH-1)) ? '0 : rd_ptr_r + 1'b1;
    end
    if (push && !pop) begin
      count_nxt = count_r + 1'b1;
    end else if (pop && !push) begin
      count_nxt = count_r - 1'b1;
    end
  end

  // Pointer registers
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r  <= '0;
    end else begin
      wr_ptr_r <= wr_ptr_nxt;
      rd_ptr_r <= rd_ptr_nxt;
      count_r  <= count_nxt;
    end
  end

  // Storage array, no reset needed
  always_ff @(posedge core_clk) begin
    if (push) begin
      mem[wr_ptr_r] <= in_data;
    end
  end

endmodule : tx_hold_fifo

// >>> rtl/usart_status_host_port.sv
`timescale 1ns/1ns
module usart_status_host_port
  import usart_status_pkg::*;
(
  // Clock and reset
  input  wire logic                         core_clk,
  input  wire logic                         rst,
  // Host parallel bus pins
  input  wire logic                         cs_n,
  input  wire logic                         rd_n,
  input  wire logic                         wr_n,
  input  wire logic                         cd,
  input  wire logic [usart_status_pkg::DATA_W-1:0] data_in,
  output logic      [usart_status_pkg::DATA_W-1:0] data_out,
  output logic                              data_oe,
  // Modem pins
  input  wire logic                         dsr_n,
  input  wire logic                         cts_n,
  output logic                              rts_n,
  output logic                              dtr_n,
  // Status pins
  output logic                              rx_char_ready,
  output logic                              tx_buffer_free,
  output logic                              sync_found,
  // Receiver core
  input  wire logic                         rx_char_valid,
  input  wire logic [usart_status_pkg::DATA_W-1:0] rx_char,
  input  wire logic                         rx_parity_bad,
  input  wire logic                         rx_stop_low,
  input  wire logic                         sync_hit,
  // Transmitter core
  input  wire logic                         tx_shift_idle,
  output logic                              tx_char_valid,
  input  wire logic                         tx_char_ready,
  output logic      [usart_status_pkg::DATA_W-1:0] tx_char,
  output logic                              send_break,
  output logic                              hunt_start,
  // Mode settings
  output logic      [1:0]                   baud_sel,
  output logic      [1:0]                   char_len,
  output logic                              parity_en,
  output logic                              parity_even,
  output logic      [1:0]                   stop_sel
);

  import usart_status_pkg::*;

  // ***********************************************
  // Pin synchronisers and bus strobes
  // ***********************************************
  logic [PIN_W-1:0] pin_s1_r;
  logic [PIN_W-1:0] pin_s2_r;
  logic             rd_prev_r;
  logic             wr_prev_r;
  logic [7:0]       wdata_r;
  logic [7:0]       wdata_nxt;
  logic             wcd_r;
  logic             wcd_nxt;
  logic             cs_s;
  logic             rd_s;
  logic             wr_s;
  logic             cd_s;
  logic             dsr_s;
  logic             cts_s;
  logic [7:0]       din_s;
  logic             rd_act;
  logic             wr_act;
  logic             rd_start;
  logic             wr_end;
  logic             status_rd;
  logic             data_rd;

  assign {cs_s, rd_s, wr_s, cd_s, dsr_s, cts_s, din_s} = pin_s2_r;
  assign rd_act    = !cs_s && !rd_s;
  assign wr_act    = !cs_s && !wr_s;
  assign rd_start  = rd_act && !rd_prev_r;
  assign wr_end    = !wr_act && wr_prev_r;
  assign status_rd = rd_start && cd_s;
  assign data_rd   = rd_start && !cd_s;

  // Follow write data and select while the strobe is low, hold them once it is high
  always_comb begin
    wdata_nxt = wr_act ? din_s : wdata_r;
    wcd_nxt   = wr_act ? cd_s : wcd_r;
  end

  // Two flops on every pin before use
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      pin_s1_r  <= PIN_RST;
      pin_s2_r  <= PIN_RST;
      rd_prev_r <= 1'b0;
      wr_prev_r <= 1'b0;
      wdata_r   <= 8'h00;
      wcd_r     <= 1'b0;
    end else begin
      pin_s1_r  <= {cs_n, rd_n, wr_n, cd, dsr_n, cts_n, data_in};
      pin_s2_r  <= pin_s1_r;
      rd_prev_r <= rd_act;
      wr_prev_r <= wr_act;
      wdata_r   <= wdata_nxt;
      wcd_r     <= wcd_nxt;
    end
  end

  // ***********************************************
  // Mode and command registers
  // ***********************************************
  phase_type  phase_r;
  phase_type  phase_nxt;
  logic [7:0] mode_r;
  logic [7:0] mode_nxt;
  logic [7:0] cmd_r;
  logic [7:0] cmd_nxt;
  logic       ctl_wr;
  logic       cmd_wr;
  logic       err_clr;
  logic       tx_enable_bit;
  logic       rx_enable_bit;

  assign ctl_wr        = wr_end && wcd_r;
  assign cmd_wr        = ctl_wr && (phase_r == EXPECT_CMD);
  assign err_clr       = cmd_wr && wdata_r[CMD_ERR_CLR];
  assign tx_enable_bit = cmd_r[CMD_TX_EN];
  assign rx_enable_bit = cmd_r[CMD_RX_EN];

  always_comb begin
    phase_nxt = phase_r;
    mode_nxt  = mode_r;
    cmd_nxt   = cmd_r;
    if (ctl_wr) begin
      unique case (phase_r)
        EXPECT_MODE: begin
          mode_nxt  = wdata_r;
          phase_nxt = EXPECT_CMD;
        end
        EXPECT_CMD: begin
          if (wdata_r[CMD_INT_RST]) begin
            cmd_nxt   = CMD_RST;
            phase_nxt = EXPECT_MODE;
          end else begin
            cmd_nxt = wdata_r & CMD_KEEP_MASK;
          end
        end
      endcase
    end
  end

  // Control registers
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      phase_r <= EXPECT_MODE;
      mode_r  <= MODE_RST;
      cmd_r   <= CMD_RST;
    end else begin
      phase_r <= phase_nxt;
      mode_r  <= mode_nxt;
      cmd_r   <= cmd_nxt;
    end
  end

  // mode fields drive the serial core
  assign baud_sel    = mode_r[MODE_BAUD_LSB +: 2];
  assign char_len    = mode_r[MODE_LEN_LSB +: 2];
  assign parity_en   = mode_r[MODE_PAR_EN];
  assign parity_even = mode_r[MODE_PAR_EVEN];
  assign stop_sel    = mode_r[MODE_STOP_LSB +: 2];
  assign rts_n       = !cmd_r[CMD_RTS];
  assign dtr_n       = !cmd_r[CMD_DTR];
  assign send_break  = cmd_r[CMD_BREAK];
  assign hunt_start  = cmd_wr && wdata_r[CMD_HUNT] && !wdata_r[CMD_INT_RST];

  // ***********************************************
  // Transmit holding buffer
  // ***********************************************
  logic tx_push;
  logic fifo_in_ready;

  // writes into a full buffer are dropped
  assign tx_push = wr_end && !wcd_r && (phase_r == EXPECT_CMD) && cmd_r != 8'h00;

  tx_hold_fifo #(
    .WIDTH (DATA_W),
    .DEPTH (FIFO_DEPTH)
  ) u_tx_fifo (
    .core_clk  (core_clk),
    .rst       (rst),
    .in_valid  (tx_push),
    .in_ready  (fifo_in_ready),
    .in_data   (wdata_r),
    .out_valid (tx_char_valid),
    .out_ready (tx_char_ready),
    .out_data  (tx_char)
  );

  // pin needs room, clear-to-send and enable
  assign tx_buffer_free = fifo_in_ready && !cts_s && tx_enable_bit;

  // ***********************************************
  // Receive holding register and flags
  // ***********************************************
  logic [7:0] rx_data_r;
  logic [7:0] rx_data_nxt;
  logic       rx_full_r;
  logic       rx_full_nxt;
  logic       pe_r;
  logic       pe_nxt;
  logic       oe_r;
  logic       oe_nxt;
  logic       fe_r;
  logic       fe_nxt;
  logic       sync_r;
  logic       sync_nxt;
  logic [7:0] len_mask;
  logic       err_ok;

  // errors only while receive is enabled
  assign err_ok = rx_char_valid && rx_enable_bit;

  // Character length keeps the low bits only
  always_comb begin
    unique case (char_len)
      2'h0: len_mask = 8'h1f;
      2'h1: len_mask = 8'h3f;
      2'h2: len_mask = 8'h7f;
      2'h3: len_mask = 8'hff;
    endcase
  end

  // Flag updates, a set beats a clear
  always_comb begin
    rx_data_nxt = rx_char_valid ? (rx_char & len_mask) : rx_data_r;
    rx_full_nxt = rx_char_valid || (rx_full_r && !data_rd);
    // framing error on low stop bit
    fe_nxt = (err_ok && rx_stop_low) || (fe_r && !err_clr);
    oe_nxt = (err_ok && rx_full_r && !data_rd) || (oe_r && !err_clr);
    pe_nxt = (err_ok && rx_parity_bad) || (pe_r && !err_clr);
    sync_nxt = sync_hit || (sync_r && !status_rd);
  end

  // Receive registers
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      rx_data_r <= 8'h00;
      rx_full_r <= 1'b0;
      pe_r      <= 1'b0;
      oe_r      <= 1'b0;
      fe_r      <= 1'b0;
      sync_r    <= 1'b0;
    end else begin
      rx_data_r <= rx_data_nxt;
      rx_full_r <= rx_full_nxt;
      pe_r      <= pe_nxt;
      oe_r      <= oe_nxt;
      fe_r      <= fe_nxt;
      sync_r    <= sync_nxt;
    end
  end

  // ready pin masked when receive disabled
  assign rx_char_ready = rx_full_r && rx_enable_bit;
  assign sync_found    = sync_r;

  // ***********************************************
  // Status byte and read path
  // ***********************************************
  logic [7:0] status_w;
  logic [7:0] dout_r;
  logic [7:0] dout_nxt;

  // fixed bit layout of the status byte
  always_comb begin
    status_w = 8'h00;
    // room in the buffer, no other terms
    status_w[ST_TX_FREE]  = fifo_in_ready;
    status_w[ST_RX_READY] = rx_char_ready;
    status_w[ST_TX_IDLE]  = tx_shift_idle;
    status_w[ST_SYNC]     = sync_found;
    status_w[ST_PARITY]   = pe_r;
    status_w[ST_OVERRUN]  = oe_r;
    status_w[ST_FRAMING]  = fe_r;
    status_w[ST_MODEM]    = !dsr_s;
  end

  always_comb begin
    dout_nxt = cd_s ? status_w : rx_data_r;
  end

  // Read data register
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      dout_r <= 8'h00;
    end else begin
      dout_r <= dout_nxt;
    end
  end

  assign data_out = dout_r;
  assign data_oe  = rd_act;

  // ***********************************************
  // Assertions
  // ***********************************************
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  status_read_a: assert property (!$past(rst) && $past(cd_s) |->
    dout_r == $past(status_w))
    else $error("status byte not presented");
  pin_mirror_a: assert property (!$past(rst) && $past(cd_s) |->
    dout_r[ST_RX_READY] == $past(rx_char_ready) &&
    dout_r[ST_TX_IDLE] == $past(tx_shift_idle))
    else $error("status does not mirror pins");
  modem_bit_a: assert property (!$past(rst) && $past(cd_s) |->
    dout_r[ST_MODEM] == !$past(dsr_s))
    else $error("modem bit wrong");
  framing_set_a: assert property (err_ok && rx_stop_low |=> fe_r)
    else $error("framing error not set");
  overrun_set_a: assert property (err_ok && rx_full_r && !data_rd |=> oe_r)
    else $error("overrun not set");
  parity_set_a: assert property (err_ok && rx_parity_bad |=> pe_r)
    else $error("parity error not set");
  tx_status_a: assert property (!$past(rst) && $past(cd_s) |->
    dout_r[ST_TX_FREE] == $past(fifo_in_ready))
    else $error("transmit status wrong");
  tx_pin_a: assert property (tx_buffer_free |-> !cts_s && tx_enable_bit)
    else $error("transmit pin without enable");
  mode_b6_a: assert property (ctl_wr && phase_r == EXPECT_MODE &&
    wdata_r == 8'hb6 |=> char_len == 2'h1 && parity_en && parity_even &&
    stop_sel == 2'h2 && baud_sel == 2'h2)
    else $error("mode B6 decode wrong");
  cmd_27_a: assert property (cmd_wr && wdata_r == 8'h27 |=>
    !rts_n && !dtr_n && tx_enable_bit && rx_enable_bit)
    else $error("command 27 decode wrong");
  upper_zero_a: assert property (!$past(cd_s) && char_len == 2'h1 &&
    $stable(char_len) |-> dout_r[7:6] == 2'h0)
    else $error("unused bits not zero");
  err_hold_a: assert property (fe_r && !err_clr |=> fe_r)
    else $error("error flag dropped");
  rx_mask_a: assert property (!rx_enable_bit |-> !rx_char_ready)
    else $error("ready not masked");
  sync_clear_a: assert property (status_rd && !sync_hit |=> !sync_r)
    else $error("sync flop not cleared");

  setup_c: cover property (ctl_wr ##[1:200] cmd_wr && wdata_r == 8'h27);
  tx_fill_c: cover property (!fifo_in_ready);
  overrun_c: cover property (oe_r && rx_enable_bit);
  status_poll_c: cover property (status_rd && sync_r);

endmodule : usart_status_host_port

// >>> dv/serial_core_model.sv
`timescale 1ns/1ns
module serial_core_model
  import usart_status_pkg::*;
(
  // Clock and reset
  input  wire logic              core_clk,
  input  wire logic              rst,
  // Transmit drain
  input  wire logic              tx_char_valid,
  output logic                   tx_char_ready,
  input  wire logic [DATA_W-1:0] tx_char,
  // Pacing from the bench
  input  wire logic              stall,
  input  wire logic              slow
);
  import usart_status_pkg::*;

  // ***********************************************
  // Drained characters, oldest first
  // ***********************************************
  logic [DATA_W-1:0] got_q[$];
  logic              tog;

  initial begin
    tx_char_ready = 1'b0;
    tog           = 1'b0;
  end

  // Log each handshake, then pick the next ready level
  always @(posedge core_clk) begin
    if (!rst && tx_char_valid === 1'b1 && tx_char_ready) begin
      got_q.push_back(tx_char);
    end
    tog = ~tog;
    #1 tx_char_ready = !stall && (!slow || tog); // Slow mode halves rate
  end
endmodule : serial_core_model

// >>> dv/tb_top.sv
`timescale 1ns/1ns
module tb_top;
  import usart_status_pkg::*;

  // ***********************************************
  // Signals
  // ***********************************************
  logic              core_clk, rst, cs_n, rd_n, wr_n, cd;
  logic [DATA_W-1:0] data_in, data_out, rx_char, tx_char;
  logic              data_oe, dsr_n, cts_n, rts_n, dtr_n;
  logic              rx_char_ready, tx_buffer_free, sync_found;
  logic              rx_char_valid, rx_parity_bad, rx_stop_low, sync_hit;
  logic              tx_shift_idle, tx_char_valid, tx_char_ready;
  logic              send_break, hunt_start, parity_en, parity_even;
  logic              stall, slow;
  logic [1:0]        baud_sel, char_len, stop_sel;
  int                error_cnt, tests_run;
  logic [7:0]        hunt_cnt = 8'h00;

  // Count one-cycle hunt pulses from the command decode
  always @(posedge core_clk) begin
    if (hunt_start === 1'b1) begin
      hunt_cnt <= hunt_cnt + 8'h01;
    end
  end

  usart_status_host_port dut (
    .core_clk(core_clk), .rst(rst), .cs_n(cs_n), .rd_n(rd_n),
    .wr_n(wr_n), .cd(cd), .data_in(data_in), .data_out(data_out),
    .data_oe(data_oe), .dsr_n(dsr_n), .cts_n(cts_n), .rts_n(rts_n),
    .dtr_n(dtr_n), .rx_char_ready(rx_char_ready),
    .tx_buffer_free(tx_buffer_free), .sync_found(sync_found),
    .rx_char_valid(rx_char_valid), .rx_char(rx_char),
    .rx_parity_bad(rx_parity_bad), .rx_stop_low(rx_stop_low),
    .sync_hit(sync_hit), .tx_shift_idle(tx_shift_idle),
    .tx_char_valid(tx_char_valid), .tx_char_ready(tx_char_ready),
    .tx_char(tx_char), .send_break(send_break), .hunt_start(hunt_start),
    .baud_sel(baud_sel), .char_len(char_len), .parity_en(parity_en),
    .parity_even(parity_even), .stop_sel(stop_sel));

  serial_core_model core (
    .core_clk(core_clk), .rst(rst), .tx_char_valid(tx_char_valid),
    .tx_char_ready(tx_char_ready), .tx_char(tx_char), .stall(stall),
    .slow(slow));

  // ***********************************************
  // Clock and helpers
  // ***********************************************
  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask : tick

  task automatic finish_test();
    $display("Comparisons %0d, mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : finish_test

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  // Host read: strobes held, answer taken 3 edges in
  task automatic rd_port(input logic c, input logic [7:0] exp);
    cd   = c;
    cs_n = 1'b0;
    rd_n = 1'b0;
    tick(3);
    check(data_out, exp);
    check(data_oe, 1'b1);
    tick(2);
    cs_n = 1'b1;
    rd_n = 1'b1;
    tick(4);
  endtask : rd_port

  // Host write: taken when the strobe goes back high
  task automatic wr_port(input logic c, input logic [7:0] d);
    cd      = c;
    data_in = d;
    cs_n    = 1'b0;
    wr_n    = 1'b0;
    tick(4);
    cs_n = 1'b1;
    wr_n = 1'b1;
    tick(5);
  endtask : wr_port

  // One received character from the receiver core
  task automatic rx_put(input logic [7:0] c, input logic pb, input logic sl);
    rx_char       = c;
    rx_parity_bad = pb;
    rx_stop_low   = sl;
    rx_char_valid = 1'b1;
    tick(1);
    rx_char_valid = 1'b0;
    tick(2);
  endtask : rx_put

  // Bounded hang guard
  initial begin
    repeat (60000) @(posedge core_clk);
    error_cnt++;
    finish_test();
  end

  // ***********************************************
  // Main sequence
  // ***********************************************
  initial begin
    error_cnt = 0;
    tests_run = 0;
    {rst, cs_n, rd_n, wr_n, cd, dsr_n, cts_n, tx_shift_idle} = 8'hff;
    {rx_char_valid, rx_parity_bad, rx_stop_low, sync_hit, slow} = 5'h00;
    data_in = 8'h00;
    rx_char = 8'h00;
    stall   = 1'b1;
    tick(10);
    rst = 1'b0;
    tick(1);
    check({rts_n, dtr_n, tx_buffer_free}, 3'h6);
    rd_port(1'b1, 8'h05);
    // Data before setup must not reach the buffer
    wr_port(1'b0, 8'h11);
    check(tx_char_valid, 1'b0);
    wr_port(1'b1, 8'hb6);
    check({stop_sel, parity_even, parity_en, char_len, baud_sel}, 8'hb6);
    check(char_len, 2'h1);
    cts_n = 1'b0;
    wr_port(1'b1, 8'h26);
    check(tx_buffer_free, 1'b0);
    wr_port(1'b1, 8'h27);
    check({rts_n, dtr_n, tx_buffer_free}, 3'h1);
    cts_n = 1'b1;
    tick(4);
    check(tx_buffer_free, 1'b0);
    rd_port(1'b1, 8'h05);
    cts_n = 1'b0;
    // Fill the buffer with the drain stalled
    for (int i = 0; i < FIFO_DEPTH; i++) begin
      rd_port(1'b1, 8'h05);
      wr_port(1'b0, 8'h40 + i[7:0]);
    end
    rd_port(1'b1, 8'h04);
    check(tx_buffer_free, 1'b0);
    wr_port(1'b0, 8'hee);
    stall = 1'b0;
    slow  = 1'b1;
    for (int n = 0; n < 200 && core.got_q.size() < 8; n++) tick(1);
    tick(20);
    check(core.got_q.size(), 8'h08);
    for (int i = 0; i < core.got_q.size(); i++) begin
      check(core.got_q[i], 8'h40 + i[7:0]);
    end
    check(tx_buffer_free, 1'b1);
    // Received character, upper bits dropped for 6-bit length
    rx_put(8'hed, 1'b0, 1'b0);
    for (int n = 0; n < 20 && rx_char_ready !== 1'b1; n++) tick(1);
    check(rx_char_ready, 1'b1);
    rd_port(1'b1, 8'h07);
    rd_port(1'b0, 8'h2d);
    check(rx_char_ready, 1'b0);
    // Parity and framing, then overrun by an unread character
    rx_put(8'h01, 1'b1, 1'b1);
    rx_put(8'h02, 1'b0, 1'b0);
    rd_port(1'b1, 8'h3f);
    rd_port(1'b0, 8'h02);
    rd_port(1'b1, 8'h3d);
    wr_port(1'b1, 8'h37);
    rd_port(1'b1, 8'h05);
    // Receive disabled masks ready and errors
    wr_port(1'b1, 8'h23);
    rx_put(8'h03, 1'b1, 1'b0);
    check(rx_char_ready, 1'b0);
    rd_port(1'b1, 8'h05);
    wr_port(1'b1, 8'h27);
    rd_port(1'b0, 8'h03);
    // Sync detect set, then cleared by a status read
    sync_hit = 1'b1;
    tick(1);
    sync_hit = 1'b0;
    tick(2);
    check(sync_found, 1'b1);
    rd_port(1'b1, 8'h45);
    check(sync_found, 1'b0);
    // Modem ready and shifter busy
    dsr_n         = 1'b0;
    tx_shift_idle = 1'b0;
    tick(4);
    rd_port(1'b1, 8'h81);
    // Break level, hunt pulse, then internal reset back to mode phase
    wr_port(1'b1, 8'h2f);
    check(send_break, 1'b1);
    wr_port(1'b1, 8'ha7);
    check(send_break, 1'b0);
    check(hunt_cnt, 8'h01);
    wr_port(1'b1, 8'h40);
    check({rts_n, dtr_n, tx_buffer_free}, 3'h6);
    wr_port(1'b1, 8'h4e);
    check(char_len, 2'h3);
    check(baud_sel, 2'h2);
    finish_test();
  end
endmodule : tb_top
